// ===== nv_store_ctrl.sv
// data nv store access controller: register port, unlock, timers
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module nv_store_ctrl
#(
    parameter int PWRT_CYCLES  = nv_store_pkg::PWRT_CYCLES,
    parameter int STORE_CYCLES = nv_store_pkg::STORE_CYCLES
)
(
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst_b,
    input  wire nv_store_pkg::rst_cause_s rst_cause,
    // register port
    input  wire nv_store_pkg::reg_req_s   reg_req,
    output logic [7:0]                    reg_rdata,
    // programming port
    input  wire logic                     code_protect,
    input  wire nv_store_pkg::prog_req_s  prog_req,
    output logic [7:0]                    prog_rdata
);
    import nv_store_pkg::*;

    localparam int PW = $clog2(PWRT_CYCLES + 1);
    localparam logic [PW-1:0] PWRT_LOAD = PW'(PWRT_CYCLES);
    localparam logic [PW-1:0] PWRT_ZERO = '0;

    logic [7:0]    addr_r;
    logic [7:0]    data_r;
    logic          rd_r;
    logic          wr_r;
    logic          permit_r;
    logic          abort_r;
    logic          done_flag_r;
    unlock_e       seq_r;
    unlock_e       seq_nxt;
    logic [1:0]    gap_r;
    logic [1:0]    gap_nxt;
    logic [PW-1:0] pwrt_r;
    logic [7:0]    reg_rdata_r;
    logic [7:0]    reg_rdata_nxt;
    logic [7:0]    prog_rdata_r;

    // decode
    wire sel_flags = reg_req.addr == OFS_FLAGS;
    wire sel_data  = reg_req.addr == OFS_DATA;
    wire sel_addr  = reg_req.addr == OFS_ADDR;
    wire sel_ctrl  = reg_req.addr == OFS_CTRL;
    wire sel_key   = reg_req.addr == OFS_KEY;
    wire wr_flags  = reg_req.wr && sel_flags;
    wire wr_data   = reg_req.wr && sel_data;
    wire wr_addr   = reg_req.wr && sel_addr;
    wire wr_ctrl   = reg_req.wr && sel_ctrl;
    wire wr_key    = reg_req.wr && sel_key;
    wire any_acc   = reg_req.wr || reg_req.rd;
    wire por_now   = !rst_b && rst_cause.power_on;
    wire cut_now   = rst_cause.ext_pin || rst_cause.watchdog
                     || rst_cause.brownout;

    wire       cell_busy;
    wire       cell_done;
    wire [7:0] cpu_cell_data;
    wire [7:0] prog_cell_data;

    wire pwrt_done  = pwrt_r == PWRT_ZERO;
    wire key1_ok    = wr_key && reg_req.wdata == KEY_FIRST;
    wire key2_ok    = wr_key && reg_req.wdata == KEY_SECOND
                      && gap_r == KEY_GAP;
    wire start_req  = wr_ctrl && reg_req.wdata[BIT_WR];
    wire cpu_start  = start_req && seq_r == SEQ_ARMED
                      && gap_r == START_GAP
                      && permit_r
                      && pwrt_done
                      && !wr_r && !cell_busy;
    wire prog_start = prog_req.wr && !code_protect
                      && pwrt_done && !wr_r && !cell_busy && !cpu_start;
    wire cell_start = cpu_start || prog_start;
    wire cpu_done   = cell_done && wr_r;
    wire [7:0] st_addr = cpu_start ? addr_r : prog_req.addr;
    wire [7:0] st_data = cpu_start ? data_r : prog_req.wdata;
    wire [7:0] ctrl_view = {4'h0, abort_r, permit_r, wr_r, rd_r};

    // unlock tracker: exact bytes at exact spacing
    always_comb
    begin
        seq_nxt = seq_r;
        gap_nxt = (gap_r == GAP_MAX) ? gap_r : gap_r + 2'h1;
        case (seq_r)
            SEQ_IDLE:
            begin
                if (key1_ok)
                begin
                    seq_nxt = SEQ_GOT_FIRST;
                    gap_nxt = 2'h1;
                end
            end
            SEQ_GOT_FIRST:
            begin
                if (key2_ok)
                begin
                    seq_nxt = SEQ_ARMED;
                    gap_nxt = 2'h1;
                end
                else if (any_acc || gap_r > KEY_GAP)
                    seq_nxt = SEQ_IDLE;
            end
            SEQ_ARMED:
            begin
                if (any_acc || gap_r > START_GAP)
                    seq_nxt = SEQ_IDLE;
            end
            default:
                seq_nxt = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            seq_r <= SEQ_IDLE;
            gap_r <= GAP_MAX;
        end
        else
        begin
            seq_r <= seq_nxt;
            gap_r <= gap_nxt;
        end
    end

    // power-up timer, started only by a power-on reset
    always_ff @(posedge sys_clk)
    begin
        if (por_now)
            pwrt_r <= PWRT_LOAD;
        else if (!pwrt_done)
            pwrt_r <= pwrt_r - 1'b1;
    end

    // address and data keep their contents over non power-on resets
    always_ff @(posedge sys_clk)
    begin
        if (por_now)
            addr_r <= ADDR_RST;
        else if (rst_b && wr_addr)
            addr_r <= reg_req.wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (por_now)
            data_r <= DATA_RST;
        else if (rst_b && wr_data)
            data_r <= reg_req.wdata;
        else if (rst_b && rd_r)
            data_r <= cpu_cell_data;
    end

    // read start: one-cycle pulse, software cannot clear it
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            rd_r <= 1'b0;
        else
            rd_r <= wr_ctrl && reg_req.wdata[BIT_RD];
    end

    // store start bit follows the store from start to done
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            wr_r <= 1'b0;
        else if (cpu_start)
            wr_r <= 1'b1;
        else if (cpu_done)
            wr_r <= 1'b0;
    end

    // permit: only power-on clears it in hardware
    always_ff @(posedge sys_clk)
    begin
        if (por_now)
            permit_r <= 1'b0;
        else if (rst_b && wr_ctrl)
            permit_r <= reg_req.wdata[BIT_PERMIT];
    end

    // abort flag caught while a store is cut by reset
    always_ff @(posedge sys_clk)
    begin
        if (por_now)
            abort_r <= 1'b0;
        else if (!rst_b)
            abort_r <= abort_r || (wr_r && cut_now);
        else if (cpu_done)
            abort_r <= 1'b0;
        else if (wr_ctrl)
            abort_r <= reg_req.wdata[BIT_ABORT];
    end

    // done flag: set beats a same-cycle clear
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            done_flag_r <= 1'b0;
        else if (cpu_done)
            done_flag_r <= 1'b1;
        else if (wr_flags)
            done_flag_r <= reg_req.wdata[BIT_DONE];
    end

    // read data, registered one cycle after the strobe
    assign reg_rdata_nxt = !reg_req.rd ? ZERO8 :
                           sel_data    ? data_r :
                           sel_addr    ? addr_r :
                           sel_ctrl    ? ctrl_view :
                           sel_flags   ? {done_flag_r, 7'h00} :
                           ZERO8;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            reg_rdata_r <= ZERO8;
        else
            reg_rdata_r <= reg_rdata_nxt;
    end

    // programming port reads nothing while protected
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
            prog_rdata_r <= ZERO8;
        else if (prog_req.rd && !code_protect)
            prog_rdata_r <= prog_cell_data;
        else
            prog_rdata_r <= ZERO8;
    end

    nv_cell_array #(
        .STORE_CYCLES (STORE_CYCLES)
    ) u_cells (
        .sys_clk   (sys_clk),
        .rst_b     (rst_b),
        .start     (cell_start),
        .st_addr   (st_addr),
        .st_data   (st_data),
        .busy      (cell_busy),
        .done      (cell_done),
        .rd_addr_a (addr_r),
        .rd_data_a (cpu_cell_data),
        .rd_addr_b (prog_req.addr),
        .rd_data_b (prog_cell_data)
    );

    assign reg_rdata  = reg_rdata_r;
    assign prog_rdata = prog_rdata_r;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    int unsigned busy_len;
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b || cpu_start)
            busy_len <= 0;
        else if (wr_r)
            busy_len <= busy_len + 1;
    end

    chk_rd_self_clear: assert property (
        rd_r |=> !rd_r || $past(wr_ctrl && reg_req.wdata[BIT_RD]))
        else $error("read start bit did not clear");

    chk_read_fetch: assert property (
        rd_r && !wr_data |=> data_r == $past(cpu_cell_data))
        else $error("read did not load data buffer");

    chk_start_permit: assert property (
        $rose(wr_r) |-> $past(permit_r) && $past(pwrt_done))
        else $error("store started without permit");

    chk_start_sequence: assert property (
        $rose(wr_r) |-> $past(seq_r == SEQ_ARMED && gap_r == START_GAP))
        else $error("store started without unlock");

    chk_key_zero: assert property (
        reg_req.rd && sel_key |=> reg_rdata == ZERO8)
        else $error("key port read not zero");

    chk_ctrl_upper: assert property (
        reg_req.rd && sel_ctrl |=> reg_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");

    chk_done_flag_set: assert property (
        cpu_done |=> done_flag_r && !wr_r && !abort_r)
        else $error("completion did not set done flag");

    chk_wr_held: assert property (
        wr_r && !cell_done |=> wr_r)
        else $error("store start bit dropped while busy");

    chk_store_length: assert property (
        cpu_done |-> busy_len == STORE_CYCLES)
        else $error("store length differs from timer");

    chk_permit_kept: assert property (
        $fell(permit_r) |-> $past(wr_ctrl))
        else $error("permit cleared by hardware");

    chk_pwrt_block: assert property (
        !pwrt_done |-> !cell_start)
        else $error("store started under power-up timer");

    cov_read: cover property (rd_r ##1 reg_req.rd && sel_data);
    cov_store_done: cover property ($rose(wr_r) ##[1:300] cpu_done);
    cov_refused: cover property (start_req && permit_r && !cpu_start);
    cov_clear_race: cover property (cpu_done && wr_flags);

endmodule

// ===== nv_store_pkg.sv
// package: data nv store register map, fields, timing and carriers
package nv_store_pkg;

    // register offsets on the register port
    localparam logic [7:0] OFS_FLAGS = 8'h0C;
    localparam logic [7:0] OFS_DATA  = 8'h9A;
    localparam logic [7:0] OFS_ADDR  = 8'h9B;
    localparam logic [7:0] OFS_CTRL  = 8'h9C;
    localparam logic [7:0] OFS_KEY   = 8'h9D;

    // field positions
    localparam int BIT_RD     = 0;
    localparam int BIT_WR     = 1;
    localparam int BIT_PERMIT = 2;
    localparam int BIT_ABORT  = 3;
    localparam int BIT_DONE   = 7;

    // array geometry
    localparam int NV_DEPTH = 128;
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 8;
    localparam int INDEX_W  = 7;

    // values after reset and fixed values
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ERASED   = 8'hFF;
    localparam logic [7:0] ZERO8    = 8'h00;

    // unlock key bytes and exact spacing in cycles
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [1:0] KEY_GAP    = 2'h2;
    localparam logic [1:0] START_GAP  = 2'h1;
    localparam logic [1:0] GAP_MAX    = 2'h3;

    // timing
    localparam int CLK_KHZ      = 25000;
    localparam int PWRT_MS      = 72;
    localparam int PWRT_CYCLES  = PWRT_MS * CLK_KHZ;
    localparam int STORE_CYCLES = 100;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_GOT_FIRST,
        SEQ_ARMED
    } unlock_e;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;

    typedef struct packed {
        logic power_on;
        logic ext_pin;
        logic watchdog;
        logic brownout;
    } rst_cause_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } prog_req_s;

endpackage

// ===== nv_cell_array.sv
// nonvolatile cell array with timed erase-then-program store
`timescale 1ns/1ps
module nv_cell_array
#(
    parameter int STORE_CYCLES = nv_store_pkg::STORE_CYCLES
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    // store request
    input  wire logic        start,
    input  wire logic [7:0]  st_addr,
    input  wire logic [7:0]  st_data,
    output logic             busy,
    output logic             done,
    // two read ports
    input  wire logic [7:0]  rd_addr_a,
    output logic [7:0]       rd_data_a,
    input  wire logic [7:0]  rd_addr_b,
    output logic [7:0]       rd_data_b
);
    import nv_store_pkg::*;

    localparam int CW = $clog2(STORE_CYCLES + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(STORE_CYCLES - 1);
    localparam logic [CW-1:0] ERASE_AT = CW'(STORE_CYCLES / 2);
    localparam logic [CW-1:0] CNT_ZERO = '0;

    logic [DATA_W-1:0]  mem [NV_DEPTH];
    logic [CW-1:0]      cnt_r;
    logic               busy_r;
    logic               done_r;
    logic [INDEX_W-1:0] tgt_idx_r;
    logic [7:0]         tgt_data_r;
    logic               tgt_ok_r;

    // timer owns the store length; reset cuts it short
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cnt_r  <= CNT_ZERO;
        end
        else
        begin
            done_r <= 1'b0;
            if (start && !busy_r)
            begin
                busy_r <= 1'b1;
                cnt_r  <= CNT_LOAD;
            end
            else if (busy_r && cnt_r == CNT_ZERO)
            begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
            end
            else if (busy_r)
                cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (start && !busy_r)
        begin
            tgt_idx_r  <= st_addr[INDEX_W-1:0];
            tgt_data_r <= st_data;
            tgt_ok_r   <= ~st_addr[7];
        end
    end

    // erase half way through, program at the end
    always_ff @(posedge sys_clk)
    begin
        if (rst_b && busy_r && tgt_ok_r)
        begin
            if (cnt_r == CNT_ZERO)
                mem[tgt_idx_r] <= tgt_data_r;
            else if (cnt_r == ERASE_AT)
                mem[tgt_idx_r] <= ERASED;
        end
    end

    assign rd_data_a = rd_addr_a[7] ? ZERO8 : mem[rd_addr_a[INDEX_W-1:0]];
    assign rd_data_b = rd_addr_b[7] ? ZERO8 : mem[rd_addr_b[INDEX_W-1:0]];
    assign busy      = busy_r;
    assign done      = done_r;

endmodule

// ===== nv_prog_host.sv
// programming-port host model used by the nv store bench
`timescale 1ns/1ps
module nv_prog_host
(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_b,
    // commands from the bench
    input  wire logic                   go_rd,
    input  wire logic                   go_wr,
    input  wire logic [7:0]             go_addr,
    input  wire logic [7:0]             go_data,
    output logic [7:0]                  got_data,
    // programming port
    output nv_store_pkg::prog_req_s     prog_req,
    input  wire logic [7:0]             prog_rdata
);
    import nv_store_pkg::*;

    logic rd_q;

    // one-cycle request; idle lines toggle so stale values never match
    always_ff @(posedge sys_clk)
    begin
        if (!rst_b)
        begin
            prog_req <= '0;
            rd_q     <= 1'b0;
        end
        else
        begin
            prog_req.addr  <= (go_rd || go_wr) ? go_addr : ~prog_req.addr;
            prog_req.wdata <= (go_rd || go_wr) ? go_data : ~prog_req.wdata;
            prog_req.wr    <= go_wr;
            prog_req.rd    <= go_rd;
            rd_q           <= prog_req.rd;
            if (rd_q)
                got_data <= prog_rdata;
        end
    end
endmodule

// ===== nv_store_ctrl_tb_top.sv
// self-checking bench for the data nv store access controller
`timescale 1ns/1ps
module nv_store_ctrl_tb_top;
    import nv_store_pkg::*;

    localparam int PWRT = 40;
    localparam int STO  = 8;

    logic       sys_clk;
    logic       rst_b;
    rst_cause_s rst_cause;
    reg_req_s   reg_req;
    logic [7:0] reg_rdata;
    logic       code_protect;
    prog_req_s  prog_req;
    logic [7:0] prog_rdata;
    logic       go_rd;
    logic       go_wr;
    logic [7:0] go_addr;
    logic [7:0] go_data;
    logic [7:0] got_data;
    int         err_total;
    int         n_tests;
    logic [7:0] v;

    always #20 sys_clk = ~sys_clk;

    nv_store_ctrl #(.PWRT_CYCLES(PWRT), .STORE_CYCLES(STO)) dut
    (
        .sys_clk      (sys_clk),
        .rst_b        (rst_b),
        .rst_cause    (rst_cause),
        .reg_req      (reg_req),
        .reg_rdata    (reg_rdata),
        .code_protect (code_protect),
        .prog_req     (prog_req),
        .prog_rdata   (prog_rdata)
    );

    nv_prog_host host
    (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .go_rd      (go_rd),
        .go_wr      (go_wr),
        .go_addr    (go_addr),
        .go_data    (go_data),
        .got_data   (got_data),
        .prog_req   (prog_req),
        .prog_rdata (prog_rdata)
    );

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // one bus cycle; the request stands until the next call
    task automatic cyc(input logic w, r, input logic [7:0] a, d);
        reg_req <= '{a, d, w, r};
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, d);
        cyc(1'b1, 1'b0, a, d);
    endtask

    task automatic nop(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        cyc(1'b0, 1'b1, a, 8'h00);
        reg_req <= '0;
        #1 q = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic expect_reg(input string nm, input logic [7:0] a, exp);
        rd(a, v);
        chk(nm, v, exp);
    endtask

    task automatic check_loc(input string nm, input logic [7:0] a, exp);
        wr(OFS_ADDR, a);
        wr(OFS_CTRL, 8'h01);
        nop(1);
        expect_reg(nm, OFS_DATA, exp);
    endtask

    task automatic unlock(input logic [7:0] k1, k2, c, input int gap);
        wr(OFS_KEY, k1);
        nop(gap - 1);
        wr(OFS_KEY, k2);
        wr(OFS_CTRL, c);
    endtask

    task automatic store(input logic [7:0] a, d);
        wr(OFS_ADDR, a);
        wr(OFS_DATA, d);
        wr(OFS_CTRL, 8'h04);
        unlock(8'h55, 8'hAA, 8'h06, 2);
    endtask

    task automatic wait_done();
        int i;
        for (i = 0; i < 40; i++)
        begin
            rd(OFS_CTRL, v);
            if (v[BIT_WR] === 1'b0)
                break;
        end
        if (i == 40)
        begin
            chk("store timeout", 8'h01, 8'h00);
            report_and_stop();
        end
    endtask

    task automatic do_reset(input rst_cause_s c, input int n);
        rst_cause <= c;
        rst_b     <= 1'b0;
        repeat (n) @(posedge sys_clk);
        rst_b     <= 1'b1;
        rst_cause <= '0;
        @(posedge sys_clk);
    endtask

    task automatic prog_op(input logic w, input logic [7:0] a, d);
        go_wr   <= w;
        go_rd   <= ~w;
        go_addr <= a;
        go_data <= d;
        @(posedge sys_clk);
        go_wr <= 1'b0;
        go_rd <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic s_reset();
        expect_reg("ctrl", OFS_CTRL, 8'h00);
        expect_reg("key", OFS_KEY, 8'h00);
        expect_reg("addr", OFS_ADDR, ADDR_RST);
        expect_reg("data", OFS_DATA, DATA_RST);
        expect_reg("unmapped", 8'h50, 8'h00);
        store(8'h10, 8'h3C);
        expect_reg("ctrl pwrt", OFS_CTRL, 8'h04);
        nop(PWRT);
    endtask

    task automatic s_store();
        store(8'h00, 8'hA5);
        expect_reg("ctrl busy", OFS_CTRL, 8'h06);
        wait_done();
        expect_reg("flags", OFS_FLAGS, 8'h80);
        expect_reg("ctrl done", OFS_CTRL, 8'h04);
        store(8'h7F, 8'h5A);
        wait_done();
        check_loc("loc 00", 8'h00, 8'hA5);
        check_loc("loc 7F", 8'h7F, 8'h5A);
        expect_reg("ctrl rd", OFS_CTRL, 8'h00);
        expect_reg("data hold", OFS_DATA, 8'h5A);
        wr(OFS_DATA, 8'h33);
        expect_reg("data sw", OFS_DATA, 8'h33);
        expect_reg("flags kept", OFS_FLAGS, 8'h80);
        wr(OFS_FLAGS, 8'h00);
        expect_reg("flags clr", OFS_FLAGS, 8'h00);
        store(8'h80, 8'h11);
        wait_done();
        check_loc("loc 80", 8'h80, 8'h00);
        check_loc("loc 00 kept", 8'h00, 8'hA5);
        wr(OFS_FLAGS, 8'h00);
    endtask

    task automatic s_refuse();
        logic [7:0] k1 [4] = '{8'h55, 8'h55, 8'hAA, 8'h55};
        logic [7:0] k2 [4] = '{8'hAA, 8'hAA, 8'h55, 8'hAB};
        int         gp [4] = '{1, 3, 2, 2};
        wr(OFS_ADDR, 8'h00);
        wr(OFS_DATA, 8'hC3);
        wr(OFS_CTRL, 8'h04);
        for (int i = 0; i < 4; i++)
        begin
            unlock(k1[i], k2[i], 8'h06, gp[i]);
            expect_reg("ctrl bad seq", OFS_CTRL, 8'h04);
        end
        wr(OFS_CTRL, 8'h00);
        unlock(8'h55, 8'hAA, 8'h02, 2);
        expect_reg("ctrl no permit", OFS_CTRL, 8'h00);
        unlock(8'h55, 8'hAA, 8'h06, 2);
        expect_reg("ctrl same write", OFS_CTRL, 8'h04);
        nop(STO + 4);
        expect_reg("flags none", OFS_FLAGS, 8'h00);
        check_loc("loc 00 safe", 8'h00, 8'hA5);
    endtask

    task automatic s_protect();
        code_protect <= 1'b1;
        store(8'h01, 8'h96);
        wr(OFS_CTRL, 8'h00);
        expect_reg("ctrl no clear", OFS_CTRL, 8'h02);
        wait_done();
        expect_reg("ctrl permit", OFS_CTRL, 8'h00);
        check_loc("loc 01", 8'h01, 8'h96);
        wr(OFS_FLAGS, 8'h00);
        nop(1);
        prog_op(1'b0, 8'h01, 8'h00);
        chk("prog rd prot", got_data, 8'h00);
        prog_op(1'b1, 8'h01, 8'h11);
        nop(STO + 4);
        check_loc("loc 01 prot", 8'h01, 8'h96);
        code_protect <= 1'b0;
        prog_op(1'b0, 8'h01, 8'h00);
        chk("prog rd open", got_data, 8'h96);
        prog_op(1'b1, 8'h02, 8'h69);
        nop(STO + 4);
        check_loc("loc 02 prog", 8'h02, 8'h69);
    endtask

    task automatic s_abort();
        for (int k = 0; k < 3; k++)
        begin
            store(8'h20 + 8'(k), 8'h40 + 8'(k));
            nop(2);
            do_reset(4'b0100 >> k, 3);
            expect_reg("ctrl abort", OFS_CTRL, 8'h0C);
            expect_reg("addr kept", OFS_ADDR, 8'h20 + 8'(k));
            expect_reg("data kept", OFS_DATA, 8'h40 + 8'(k));
            expect_reg("flags abort", OFS_FLAGS, 8'h00);
        end
        wr(OFS_ADDR, 8'h20);
        wr(OFS_DATA, 8'h44);
        wr(OFS_CTRL, 8'h0C);
        unlock(8'h55, 8'hAA, 8'h0E, 2);
        expect_reg("ctrl abort busy", OFS_CTRL, 8'h0E);
        nop(STO - 2);
        wr(OFS_FLAGS, 8'h00);
        expect_reg("flags race", OFS_FLAGS, 8'h80);
        wait_done();
        expect_reg("ctrl redo", OFS_CTRL, 8'h04);
        check_loc("loc 20", 8'h20, 8'h44);
    endtask

    initial
    begin
        sys_clk      = 1'b0;
        rst_b        = 1'b0;
        rst_cause    = 4'b1000;
        reg_req      = '0;
        code_protect = 1'b0;
        go_rd        = 1'b0;
        go_wr        = 1'b0;
        go_addr      = 8'h00;
        go_data      = 8'h00;
        err_total    = 0;
        n_tests      = 0;
        do_reset(4'b1000, 12);
        s_reset();
        s_store();
        s_refuse();
        s_protect();
        s_abort();
        report_and_stop();
    end
endmodule
